// File: rtl/fph_ctrl.sv
`timescale 1ns/1ps
module fph_ctrl
  import fph_pkg::*;
#(
  parameter int POLL_DWELL = POLL_DWELL_CYC,
  parameter int STEP_UNIT  = STEP_UNIT_CYC,
  parameter int BYTE_GAP   = BYTE_GAP_CYC
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       host_wr,
  input  wire logic [7:0] host_wr_data,
  input  wire logic       host_rd,
  input  wire logic       ccr_wr,
  input  wire logic [7:0] ccr_data,
  input  wire logic       dsr_wr,
  input  wire logic [7:0] dsr_data,
  input  wire logic       dor_wr,
  input  wire logic [7:0] dor_data,
  input  wire logic       index_pin,
  output logic            host_transfer_ready,
  output logic            transfer_direction,
  output logic            cmd_busy,
  output logic      [7:0] res_data,
  output logic            int_out,
  output logic      [1:0] data_rate,
  output logic      [2:0] precomp,
  output logic      [3:0] drive_select_lines,
  output logic      [3:0] motor_enable,
  output logic            fifo_enabled,
  output logic      [3:0] fifo_threshold,
  output logic            fifo_byte_mode,
  output logic            implied_seek_en,
  output logic            poll_enabled
);

  localparam int PW = $clog2(POLL_DWELL + 1);
  localparam int SW = $clog2(SRT_SPAN * STEP_UNIT + 1);
  localparam int GW = $clog2(BYTE_GAP + 1);

  if (BYTE_GAP < 1 || BYTE_GAP > CMD_GAP_MAX_CYC || POLL_DWELL < 1 || STEP_UNIT < 1) begin : g_chk
    $error("fph_ctrl: timing parameter out of range");
  end

  // software reset clears the sequencer but not rate or precomp
  logic sw_rst;
  logic rst_all;
  assign sw_rst  = (dor_wr && !dor_data[DOR_RST_N_BIT]) || (dsr_wr && dsr_data[DSR_SWRST_BIT]);
  assign rst_all = sys_rst || sw_rst;

  logic idx_q;
  fph_sync #(.W(1)) u_idx_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (index_pin),
    .q       (idx_q)
  );

  // ---------------- command sequencer state
  fph_state_t st_reg, st_next;
  logic [7:0]    op_reg, op_next;
  logic [3:0]    left_reg, left_next;
  logic [7:0]    p1_reg, p1_next, p2_reg, p2_next, p3_reg, p3_next;
  logic [GW-1:0] gap_reg, gap_next;
  logic [2:0]    res_left_reg, res_left_next;
  logic [7:0]    res_reg, res_next, res_b2_reg, res_b2_next;
  logic [1:0]    idx_cnt_reg, idx_cnt_next;
  logic          idx_d_reg;
  logic          rqm_reg, dio_reg, busy_reg, byte_mode_reg;
  logic          do_exec;
  logic [3:0]    pos;

  // ---------------- status queue, polling, seek state
  logic [3:0]    pend_reg, pend_next, pend_seek_reg, pend_seek_next;
  logic          int_reg, int_next;
  logic [1:0]    sense_drv;
  logic [7:0]    pcn_reg [NUM_DRIVES];
  logic [7:0]    pcn_next [NUM_DRIVES];

  function automatic logic [3:0] param_len(input logic [7:0] op);
    case (op[4:0])
      OP_SPECIFY:          param_len = 4'h2;
      OP_RECAL:            param_len = 4'h1;
      OP_SEEK:             param_len = 4'h2;
      OP_CONFIGURE:        param_len = 4'h3;
      OP_READ, OP_WRITE:   param_len = 4'h8;
      default:             param_len = 4'h0;
    endcase
  endfunction

  always_comb begin
    sense_drv = 2'h0;
    for (int i = NUM_DRIVES - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        sense_drv = 2'(i);
      end
    end
  end

  logic poll_act_reg;

  always_comb begin
    st_next       = st_reg;
    op_next       = op_reg;
    left_next     = left_reg;
    p1_next       = p1_reg;
    p2_next       = p2_reg;
    p3_next       = p3_reg;
    gap_next      = gap_reg;
    res_left_next = res_left_reg;
    res_next      = res_reg;
    res_b2_next   = res_b2_reg;
    idx_cnt_next  = idx_cnt_reg;
    do_exec       = 1'b0;
    pos           = param_len(op_reg) - left_reg;
    unique case (st_reg)
      ST_IDLE: begin
        if (host_wr) begin
          op_next   = host_wr_data;
          left_next = param_len(host_wr_data);
          gap_next  = GW'(BYTE_GAP);
          st_next   = poll_act_reg ? ST_POLLWAIT : ST_GAP;
        end
      end
      ST_POLLWAIT: begin
        if (!poll_act_reg) begin
          st_next = ST_GAP;
        end
      end
      ST_PARAM: begin
        if (host_wr) begin
          if (pos == 4'h0) p1_next = host_wr_data;
          if (pos == 4'h1) p2_next = host_wr_data;
          if (pos == 4'h2) p3_next = host_wr_data;
          left_next = left_reg - 4'h1;
          gap_next  = GW'(BYTE_GAP);
          st_next   = ST_GAP;
        end
      end
      ST_GAP: begin
        if (gap_reg != '0) begin
          gap_next = gap_reg - GW'(1);
        end else if (left_reg != 4'h0) begin
          st_next = ST_PARAM;
        end else begin
          do_exec = 1'b1;
          st_next = ST_IDLE;
          unique case (op_reg[4:0])
            OP_SPECIFY, OP_CONFIGURE, OP_RECAL, OP_SEEK: st_next = ST_IDLE;
            OP_SENSE_INT: begin
              st_next = ST_RESULT;
              if (pend_reg != 4'h0) begin
                res_left_next = 3'h2;
                res_next      = (pend_seek_reg[sense_drv] ? ST0_SEEK_END : ST0_POLL_CHG)
                                | {6'h00, sense_drv};
                res_b2_next   = pcn_reg[sense_drv];
              end else begin
                res_left_next = 3'h1;
                res_next      = ST0_INVALID;
              end
            end
            OP_READ, OP_WRITE: begin
              idx_cnt_next = 2'h0;
              st_next      = ST_EXEC;
            end
            default: begin
              res_left_next = 3'h1;
              res_next      = ST0_INVALID;
              st_next       = ST_RESULT;
            end
          endcase
        end
      end
      ST_EXEC: begin
        // no index pulses means no exit; the host must time out
        if (idx_q && !idx_d_reg) begin
          if (idx_cnt_reg == 2'(EXEC_INDEX_CNT - 1)) begin
            res_left_next = 3'(RW_RESULT_BYTES);
            res_next      = ST0_ABNORMAL | {6'h00, p1_reg[1:0]};
            res_b2_next   = 8'h00;
            st_next       = ST_RESULT;
          end else begin
            idx_cnt_next = idx_cnt_reg + 2'h1;
          end
        end
      end
      ST_RESULT: begin
        if (host_rd) begin
          if (res_left_reg == 3'h1) begin
            st_next = ST_IDLE;
          end else begin
            res_left_next = res_left_reg - 3'h1;
            res_next      = res_b2_reg;
            res_b2_next   = 8'h00;
          end
        end
      end
    endcase
  end

  logic cfg_fifo_dis_reg, cfg_poll_dis_reg, cfg_eis_reg;

  always_ff @(posedge clk) begin
    if (rst_all) begin
      st_reg        <= ST_IDLE;
      op_reg        <= 8'h00;
      left_reg      <= 4'h0;
      p1_reg        <= 8'h00;
      p2_reg        <= 8'h00;
      p3_reg        <= 8'h00;
      gap_reg       <= '0;
      res_left_reg  <= 3'h0;
      res_reg       <= 8'h00;
      res_b2_reg    <= 8'h00;
      idx_cnt_reg   <= 2'h0;
      idx_d_reg     <= 1'b0;
      rqm_reg       <= 1'b1;
      dio_reg       <= 1'b0;
      busy_reg      <= 1'b0;
      byte_mode_reg <= 1'b1;
    end else begin
      st_reg        <= st_next;
      op_reg        <= op_next;
      left_reg      <= left_next;
      p1_reg        <= p1_next;
      p2_reg        <= p2_next;
      p3_reg        <= p3_next;
      gap_reg       <= gap_next;
      res_left_reg  <= res_left_next;
      res_reg       <= res_next;
      res_b2_reg    <= res_b2_next;
      idx_cnt_reg   <= idx_cnt_next;
      idx_d_reg     <= idx_q;
      rqm_reg       <= (st_next == ST_IDLE || st_next == ST_PARAM || st_next == ST_RESULT);
      dio_reg       <= (st_next == ST_RESULT);
      busy_reg      <= (st_next != ST_IDLE);
      byte_mode_reg <= cfg_fifo_dis_reg || (st_next != ST_EXEC);
    end
  end

  // ---------------- configuration, rate and drive outputs
  logic [1:0] rate_reg, rate_next;
  logic [2:0] pcomp_reg, pcomp_next;
  logic [7:0] dor_reg, dor_next;
  logic [3:0] sel_reg, sel_next;
  logic [3:0] srt_reg, srt_next, hut_reg, hut_next;
  logic [6:0] hlt_reg, hlt_next;
  logic       nodma_reg, nodma_next;
  logic       cfg_fifo_dis_next, cfg_poll_dis_next, cfg_eis_next;
  logic [3:0] cfg_thr_reg, cfg_thr_next;
  logic [7:0] cfg_pretrk_reg, cfg_pretrk_next;

  always_comb begin
    rate_next         = rate_reg;
    pcomp_next        = pcomp_reg;
    dor_next          = dor_wr ? dor_data : dor_reg;
    sel_next          = 4'h1 << dor_next[1:0];
    srt_next          = srt_reg;
    hut_next          = hut_reg;
    hlt_next          = hlt_reg;
    nodma_next        = nodma_reg;
    cfg_fifo_dis_next = cfg_fifo_dis_reg;
    cfg_poll_dis_next = cfg_poll_dis_reg;
    cfg_eis_next      = cfg_eis_reg;
    cfg_thr_next      = cfg_thr_reg;
    cfg_pretrk_next   = cfg_pretrk_reg;
    if (ccr_wr) begin
      rate_next = ccr_data[1:0];
    end
    if (dsr_wr) begin
      rate_next  = dsr_data[1:0];
      pcomp_next = dsr_data[4:2];
    end
    if (do_exec && op_reg[4:0] == OP_SPECIFY) begin
      srt_next   = p1_reg[7:4];
      hut_next   = p1_reg[3:0];
      hlt_next   = p2_reg[7:1];
      nodma_next = p2_reg[0];
    end
    if (do_exec && op_reg[4:0] == OP_CONFIGURE) begin
      cfg_eis_next      = p2_reg[CFG_EIS_BIT];
      cfg_fifo_dis_next = p2_reg[CFG_FIFO_DIS_BIT];
      cfg_poll_dis_next = p2_reg[CFG_POLL_DIS_BIT];
      cfg_thr_next      = p2_reg[3:0];
      cfg_pretrk_next   = p3_reg;
    end
  end

  // timing fields carry no reset: software must specify them
  always_ff @(posedge clk) begin
    srt_reg   <= srt_next;
    hut_reg   <= hut_next;
    hlt_reg   <= hlt_next;
    nodma_reg <= nodma_next;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rate_reg  <= RATE_RST;
      pcomp_reg <= PRECOMP_RST;
      dor_reg   <= DOR_RST;
      sel_reg   <= 4'h1 << DOR_RST[1:0];
    end else begin
      rate_reg  <= rate_next;
      pcomp_reg <= pcomp_next;
      dor_reg   <= dor_next;
      sel_reg   <= sel_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      cfg_fifo_dis_reg <= CFG_FIFO_DIS_RST;
      cfg_poll_dis_reg <= CFG_POLL_DIS_RST;
      cfg_eis_reg      <= CFG_EIS_RST;
      cfg_thr_reg      <= CFG_THR_RST;
      cfg_pretrk_reg   <= CFG_PRETRK_RST;
    end else begin
      cfg_fifo_dis_reg <= cfg_fifo_dis_next;
      cfg_poll_dis_reg <= cfg_poll_dis_next;
      cfg_eis_reg      <= cfg_eis_next;
      cfg_thr_reg      <= cfg_thr_next;
      cfg_pretrk_reg   <= cfg_pretrk_next;
    end
  end

  // ---------------- simulated drive polling
  logic       ptmr_busy, ptmr_done, ptmr_start;
  logic [1:0] poll_drv_reg, poll_drv_next;
  logic       poll_act_next, poll_void_reg, poll_void_next, poll_commit;
  logic [3:0] rdy_reg, rdy_next, chg_reg, chg_next;

  // only an idle sequencer with no opcode arriving starts a loop; a loop begun runs out
  assign ptmr_start = !ptmr_busy && !ptmr_done
                      && (poll_act_reg || (!cfg_poll_dis_reg && st_reg == ST_IDLE
                                           && !host_wr));

  fph_timer #(.W(PW)) u_poll_tmr (
    .clk     (clk),
    .sys_rst (rst_all),
    .start   (ptmr_start),
    .load    (PW'(POLL_DWELL)),
    .busy    (ptmr_busy),
    .done    (ptmr_done)
  );

  always_comb begin
    poll_drv_next  = poll_drv_reg;
    poll_act_next  = poll_act_reg;
    poll_void_next = poll_void_reg;
    rdy_next       = rdy_reg;
    chg_next       = chg_reg;
    poll_commit    = 1'b0;
    if (ptmr_start && !poll_act_reg) begin
      poll_act_next  = 1'b1;
      poll_void_next = 1'b0;
      chg_next       = 4'h0;
    end
    if (st_reg == ST_IDLE && host_wr && poll_act_reg) begin
      poll_void_next = 1'b1;
    end
    if (ptmr_done) begin
      chg_next[poll_drv_reg] = !rdy_reg[poll_drv_reg];
      if (poll_drv_reg == 2'(NUM_DRIVES - 1)) begin
        poll_act_next = 1'b0;
        poll_drv_next = 2'h0;
        if (!poll_void_reg) begin
          poll_commit = 1'b1;
          rdy_next    = rdy_reg | chg_next;
        end
      end else begin
        poll_drv_next = poll_drv_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      poll_drv_reg  <= 2'h0;
      poll_act_reg  <= 1'b0;
      poll_void_reg <= 1'b0;
      rdy_reg       <= 4'h0;
      chg_reg       <= 4'h0;
    end else begin
      poll_drv_reg  <= poll_drv_next;
      poll_act_reg  <= poll_act_next;
      poll_void_reg <= poll_void_next;
      rdy_reg       <= rdy_next;
      chg_reg       <= chg_next;
    end
  end

  // ---------------- background head positioning
  logic          sk_busy_reg, sk_busy_next, sk_done, sk_start;
  logic [1:0]    sk_drv_reg, sk_drv_next;
  logic [7:0]    sk_tgt_reg, sk_tgt_next;
  logic          stmr_busy, stmr_done, stmr_start;
  logic [SW-1:0] step_load;

  assign sk_start   = do_exec && (op_reg[4:0] == OP_RECAL || op_reg[4:0] == OP_SEEK);
  assign step_load  = SW'((SRT_SPAN - int'(srt_reg)) * STEP_UNIT);
  assign stmr_start = sk_busy_reg && !stmr_busy && !stmr_done
                      && pcn_reg[sk_drv_reg] != sk_tgt_reg;

  fph_timer #(.W(SW)) u_step_tmr (
    .clk     (clk),
    .sys_rst (rst_all),
    .start   (stmr_start),
    .load    (step_load),
    .busy    (stmr_busy),
    .done    (stmr_done)
  );

  always_comb begin
    sk_busy_next = sk_busy_reg;
    sk_drv_next  = sk_drv_reg;
    sk_tgt_next  = sk_tgt_reg;
    pcn_next     = pcn_reg;
    sk_done      = 1'b0;
    if (sk_start) begin
      // a new positioning command takes over any seek in progress
      sk_busy_next = 1'b1;
      sk_drv_next  = p1_reg[1:0];
      if (op_reg[4:0] == OP_RECAL) begin
        sk_tgt_next = 8'h00;
      end else if (!op_reg[OP_REL_BIT]) begin
        sk_tgt_next = p2_reg;
      end else if (op_reg[OP_REL_DIR_BIT]) begin
        sk_tgt_next = pcn_reg[p1_reg[1:0]] + p2_reg;
      end else begin
        sk_tgt_next = pcn_reg[p1_reg[1:0]] - p2_reg;
      end
    end else if (sk_busy_reg) begin
      if (pcn_reg[sk_drv_reg] == sk_tgt_reg) begin
        sk_busy_next = 1'b0;
        sk_done      = 1'b1;
      end else if (stmr_done) begin
        if (pcn_reg[sk_drv_reg] < sk_tgt_reg) begin
          pcn_next[sk_drv_reg] = pcn_reg[sk_drv_reg] + 8'h01;
        end else begin
          pcn_next[sk_drv_reg] = pcn_reg[sk_drv_reg] - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      sk_busy_reg <= 1'b0;
      sk_drv_reg  <= 2'h0;
      sk_tgt_reg  <= 8'h00;
      for (int i = 0; i < NUM_DRIVES; i++) begin
        pcn_reg[i] <= 8'h00;
      end
    end else begin
      sk_busy_reg <= sk_busy_next;
      sk_drv_reg  <= sk_drv_next;
      sk_tgt_reg  <= sk_tgt_next;
      pcn_reg     <= pcn_next;
    end
  end

  // ---------------- per-drive status queue and interrupt
  logic [3:0] set_mask, seek_mask, clr_mask;
  logic       sense_exec;

  assign sense_exec = do_exec && op_reg[4:0] == OP_SENSE_INT;

  always_comb begin
    seek_mask = sk_done ? (4'h1 << sk_drv_reg) : 4'h0;
    set_mask  = (poll_commit ? chg_next : 4'h0) | seek_mask;
    clr_mask  = (sense_exec && pend_reg != 4'h0) ? (4'h1 << sense_drv) : 4'h0;
    // a new event on the drive being popped survives the pop
    pend_next      = (pend_reg & ~clr_mask) | set_mask;
    pend_seek_next = (pend_seek_reg & ~set_mask) | seek_mask;
    int_next       = int_reg;
    if (sense_exec) begin
      int_next = 1'b0;
    end
    if (set_mask != 4'h0) begin
      int_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      pend_reg      <= 4'h0;
      pend_seek_reg <= 4'h0;
      int_reg       <= 1'b0;
    end else begin
      pend_reg      <= pend_next;
      pend_seek_reg <= pend_seek_next;
      int_reg       <= int_next;
    end
  end

  assign host_transfer_ready = rqm_reg;
  assign transfer_direction  = dio_reg;
  assign cmd_busy            = busy_reg;
  assign res_data            = res_reg;
  assign int_out             = int_reg;
  assign data_rate           = rate_reg;
  assign precomp             = pcomp_reg;
  assign drive_select_lines  = sel_reg;
  assign motor_enable        = dor_reg[7:4];
  assign fifo_enabled        = !cfg_fifo_dis_reg;
  assign fifo_threshold      = cfg_thr_reg;
  assign fifo_byte_mode      = byte_mode_reg;
  assign implied_seek_en     = cfg_eis_reg;
  assign poll_enabled        = !cfg_poll_dis_reg;

endmodule // fph_ctrl

// File: rtl/fph_pkg.sv
package fph_pkg;

  localparam int CLK_MHZ          = 200;
  localparam int NUM_DRIVES       = 4;

  // polling loop: one dwell per simulated drive
  localparam int POLL_LOOP_US     = 250;
  localparam int POLL_LOOP_CYC    = POLL_LOOP_US * CLK_MHZ;
  localparam int POLL_DWELL_CYC   = POLL_LOOP_CYC / NUM_DRIVES;

  // byte-to-byte handshake gap with polling off
  localparam int CMD_GAP_MAX_US   = 175;
  localparam int CMD_GAP_MAX_CYC  = CMD_GAP_MAX_US * CLK_MHZ;
  localparam int BYTE_GAP_CYC     = 4;

  // head step period is (SRT_SPAN - step rate code) step units
  localparam int STEP_UNIT_US     = 1000;
  localparam int STEP_UNIT_CYC    = STEP_UNIT_US * CLK_MHZ;
  localparam int SRT_SPAN         = 16;

  localparam int EXEC_INDEX_CNT   = 2;
  localparam int RW_RESULT_BYTES  = 7;

  localparam logic [1:0] RATE_RST    = 2'h2;
  localparam logic [2:0] PRECOMP_RST = 3'h0;
  localparam logic [7:0] DOR_RST     = 8'h00;

  // opcode low five bits
  localparam logic [4:0] OP_WRITE     = 5'h05;
  localparam logic [4:0] OP_READ      = 5'h06;
  localparam logic [4:0] OP_SPECIFY   = 5'h03;
  localparam logic [4:0] OP_RECAL     = 5'h07;
  localparam logic [4:0] OP_SENSE_INT = 5'h08;
  localparam logic [4:0] OP_SEEK      = 5'h0F;
  localparam logic [4:0] OP_CONFIGURE = 5'h13;
  localparam int OP_REL_BIT           = 7;
  localparam int OP_REL_DIR_BIT       = 6;

  localparam logic [7:0] ST0_INVALID  = 8'h80;
  localparam logic [7:0] ST0_ABNORMAL = 8'h40;
  localparam logic [7:0] ST0_SEEK_END = 8'h20;
  localparam logic [7:0] ST0_POLL_CHG = 8'hC0;

  // configure second parameter byte
  localparam int CFG_EIS_BIT          = 6;
  localparam int CFG_FIFO_DIS_BIT     = 5;
  localparam int CFG_POLL_DIS_BIT     = 4;
  localparam logic       CFG_EIS_RST      = 1'b0;
  localparam logic       CFG_FIFO_DIS_RST = 1'b1;
  localparam logic       CFG_POLL_DIS_RST = 1'b0;
  localparam logic [3:0] CFG_THR_RST      = 4'h0;
  localparam logic [7:0] CFG_PRETRK_RST   = 8'h00;

  localparam int DOR_RST_N_BIT        = 2;
  localparam int DSR_SWRST_BIT        = 7;

  typedef enum logic [2:0] {
    ST_IDLE, ST_POLLWAIT, ST_GAP, ST_PARAM, ST_EXEC, ST_RESULT
  } fph_state_t;

endpackage

// File: rtl/fph_sync.sv
`timescale 1ns/1ps
module fph_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule // fph_sync

// File: rtl/fph_timer.sv
`timescale 1ns/1ps
module fph_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         done_reg;
  logic         done_next;

  // a start while counting is ignored; load of zero never finishes
  always_comb begin
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (start && cnt_reg == '0) begin
      cnt_next = load;
    end else if (cnt_reg != '0) begin
      cnt_next  = cnt_reg - W'(1);
      done_next = (cnt_reg == W'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign busy = (cnt_reg != '0);
  assign done = done_reg;

endmodule // fph_timer

// File: dv/fph_checker.sv
`timescale 1ns/1ps
module fph_checker (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       host_wr,
  input wire logic       dor_wr,
  input wire logic [7:0] dor_data,
  input wire logic       ccr_wr,
  input wire logic       dsr_wr,
  input wire logic       host_transfer_ready,
  input wire logic       transfer_direction,
  input wire logic       cmd_busy,
  input wire logic       int_out,
  input wire logic [1:0] data_rate,
  input wire logic [2:0] precomp,
  input wire logic [3:0] drive_select_lines,
  input wire logic       fifo_byte_mode,
  input wire logic       fifo_enabled,
  input wire logic       poll_enabled
);
  localparam int GAP_MAX = 8;
  wire take = host_wr && host_transfer_ready && !transfer_direction;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_HARD_RST: assert property ($fell(sys_rst) |-> data_rate == 2'h2 && precomp == 3'h0)
    else $error("reset rate or precomp wrong");
  AST_RST_POLL: assert property ($fell(sys_rst) |-> poll_enabled && !int_out && !fifo_enabled
    && host_transfer_ready && !transfer_direction) else $error("reset state wrong");
  AST_SW_KEEP: assert property (dor_wr && !dor_data[2] && !ccr_wr && !dsr_wr
    |=> $stable(data_rate) && $stable(precomp)) else $error("soft reset moved rate");
  AST_TAKE: assert property (take |=> !host_transfer_ready)
    else $error("ready kept after byte");
  AST_GAP: assert property (take && !cmd_busy && !poll_enabled
    |-> ##[1:GAP_MAX] host_transfer_ready) else $error("byte gap too long");
  AST_DIR_BUSY: assert property (transfer_direction |-> cmd_busy)
    else $error("outward while idle");
  AST_SEL_HOLD: assert property (!$past(dor_wr) |-> $stable(drive_select_lines))
    else $error("selects moved");
  AST_BYTE_MODE: assert property (!cmd_busy |-> fifo_byte_mode)
    else $error("not byte mode");
endmodule // fph_checker
bind fph_ctrl fph_checker u_chk (.clk, .sys_rst, .host_wr, .dor_wr, .dor_data, .ccr_wr,
  .dsr_wr, .host_transfer_ready, .transfer_direction, .cmd_busy, .int_out, .data_rate,
  .precomp, .drive_select_lines, .fifo_byte_mode, .fifo_enabled, .poll_enabled);

// File: dv/fph_host.sv
`timescale 1ns/1ps
module fph_host (
  input  wire logic       clk,
  input  wire logic       rdy,
  input  wire logic       dir,
  input  wire logic [7:0] rd_data,
  output logic            wr,
  output logic      [7:0] wr_data,
  output logic            rd
);
  int to_count = 0;
  initial begin
    wr = 1'b0;
    wr_data = 8'h00;
    rd = 1'b0;
  end
  // fixed cycle bound, not loop speed, so a lock-up cannot hang the host
  task automatic hs(input logic d);
    int n;
    n = 0;
    while (!(rdy === 1'b1 && dir === d) && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 2000) to_count++;
  endtask
  task automatic send(input logic [7:0] b);
    hs(1'b0);
    wr = 1'b1;
    wr_data = b;
    @(posedge clk);
    #1;
    wr = 1'b0;
    wr_data = ~b;
  endtask
  task automatic get(output logic [7:0] b);
    hs(1'b1);
    b = rd_data;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    @(posedge clk);
    #1;
  endtask
endmodule // fph_host

// File: dv/fdc_poll_handshake_init_tb.sv
`timescale 1ns/1ps
module fdc_poll_handshake_init_tb;
  logic clk = 0, sys_rst, host_wr, host_rd, ccr_wr, dsr_wr, dor_wr;
  logic index_pin, host_transfer_ready, transfer_direction, cmd_busy, int_out;
  logic fifo_enabled, fifo_byte_mode, implied_seek_en, poll_enabled;
  logic [7:0] host_wr_data, ccr_data, dsr_data, dor_data, res_data, rb;
  logic [1:0] data_rate;
  logic [2:0] precomp;
  logic [3:0] drive_select_lines, motor_enable, fifo_threshold;
  logic [15:0] rows [5] = '{16'h08C0, 16'h08C1, 16'h08C2, 16'h08C3, 16'h0880};
  int err_count = 0, compares = 0, cyc = 0, t0;
  fph_ctrl #(.POLL_DWELL(20), .STEP_UNIT(8)) dut (.clk, .sys_rst, .host_wr, .host_wr_data,
    .host_rd, .ccr_wr, .ccr_data, .dsr_wr, .dsr_data, .dor_wr, .dor_data, .index_pin,
    .host_transfer_ready, .transfer_direction, .cmd_busy, .res_data, .int_out, .data_rate,
    .precomp, .drive_select_lines, .motor_enable, .fifo_enabled, .fifo_threshold,
    .fifo_byte_mode, .implied_seek_en, .poll_enabled);
  fph_host h (.clk, .rdy(host_transfer_ready), .dir(transfer_direction), .rd_data(res_data),
    .wr(host_wr), .wr_data(host_wr_data), .rd(host_rd));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic hreset();
    sys_rst = 1;
    repeat (12) @(posedge clk);
    #1 sys_rst = 0;
  endtask
  task automatic reg_wr(input int s, input logic [7:0] d);
    {ccr_wr, dsr_wr, dor_wr} = 3'b100 >> s;
    {ccr_data, dsr_data, dor_data} = {3{d}};
    @(posedge clk);
    #1 {ccr_wr, dsr_wr, dor_wr} = 3'b000;
    @(posedge clk);
    #1;
  endtask
  task automatic sense(input logic [15:0] r, input logic [7:0] cyl = 8'h00);
    logic [7:0] b;
    h.send(r[15:8]);
    h.get(b);
    chk(b, r[7:0]);
    if (r[7:0] != 8'h80) begin
      h.get(b);
      chk(b, cyl);
    end
    chk(transfer_direction, 1'b0);
  endtask
  task automatic wint();
    int n;
    n = 0;
    while (int_out !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    chk(int_out, 1'b1);
  endtask
  task automatic end_of_test();
    err_count += h.to_count;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {ccr_wr, dsr_wr, dor_wr, index_pin} = 4'h0;
    {ccr_data, dsr_data, dor_data} = 24'h000000;
    hreset();
    chk({data_rate, precomp}, 5'h10);
    chk({host_transfer_ready, transfer_direction, poll_enabled, fifo_byte_mode}, 4'hB);
    chk({fifo_enabled, drive_select_lines}, 5'h01);
    $display("test reset done");
    wint();
    for (int i = 0; i < 5; i++) begin
      sense(rows[i]);
      if (i == 0) chk(int_out, 1'b0);
    end
    chk(drive_select_lines, 4'h1);
    $display("test poll flags done");
    reg_wr(1, 8'h15);
    reg_wr(2, 8'h00);
    chk({data_rate, precomp}, 5'h0D);
    reg_wr(1, 8'h95);
    chk({data_rate, precomp}, 5'h0D);
    reg_wr(0, 8'h03);
    chk(data_rate, 2'h3);
    $display("test soft reset done");
    hreset();
    // first byte lands inside the first poll loop
    repeat (10) @(posedge clk);
    #1;
    h.send(8'h13);
    t0 = cyc;
    h.send(8'h00);
    chk(cyc - t0 >= 60, 1'b1);
    h.send(8'h57);
    h.send(8'h00);
    h.hs(1'b0);
    chk({poll_enabled, fifo_enabled, implied_seek_en, fifo_threshold}, 8'h37);
    repeat (200) @(posedge clk);
    #1;
    chk(int_out, 1'b0);
    sense(16'h0880);
    $display("test configure done");
    reg_wr(2, 8'h1D);
    chk({motor_enable, drive_select_lines}, 8'h12);
    h.send(8'h03);
    h.send(8'hF0);
    h.send(8'h02);
    for (int i = 0; i < 2; i++) begin
      h.send(i == 0 ? 8'h0F : 8'h07);
      h.send(8'h00);
      if (i == 0) h.send(8'h03);
      h.hs(1'b0);
      chk({host_transfer_ready, transfer_direction, cmd_busy, int_out}, 4'h8);
      wint();
      sense(16'h0820, i == 0 ? 8'h03 : 8'h00);
      chk(int_out, 1'b0);
    end
    $display("test seek and recalibrate done");
    for (int i = 0; i < 9; i++) begin
      h.send(i == 0 ? 8'h06 : 8'h01);
    end
    repeat (50) @(posedge clk);
    #1;
    chk({host_transfer_ready, cmd_busy, fifo_byte_mode}, 3'h2);
    repeat (2) begin
      index_pin = 1'b1;
      repeat (3) @(posedge clk);
      #1 index_pin = 1'b0;
      repeat (3) @(posedge clk);
      #1;
    end
    h.get(rb);
    chk(rb, 8'h41);
    repeat (6) begin
      h.get(rb);
      chk(rb, 8'h00);
    end
    chk({transfer_direction, fifo_byte_mode}, 2'h1);
    $display("test read execution done");
    end_of_test();
  end
endmodule // fdc_poll_handshake_init_tb
